/* owr_rx.sv */
// single-wire dimming command receiver top
`include "owr_defines.svh"
`default_nettype none
module owr_rx (
  input  wire logic       clk_in,          // 20 MHz internal clock
  input  wire logic       arst_n_in,       // async reset, low
  input  wire logic       line_in,         // enable pin level
  output logic            ack_pulldown_out,// open-drain output enable
  output logic            line_drv_out,    // pin output value, always low
  output logic [8:0]      bright_out,      // applied brightness
  input  wire logic       cmd_ready_in,    // consumer accepts command
  output logic            cmd_valid_out,   // buffered command ready
  output owr_pkg::owr_cmd_s cmd_out,       // buffered command
  output logic            frame_err_out    // last frame discarded
);
  localparam logic [`OWR_CNT_W-1:0] CLOSE_CYC = `OWR_CNT_W'(`OWR_CLOSE_CYC);
  localparam logic [`OWR_CNT_W-1:0] VALID_CYC = `OWR_CNT_W'(`OWR_VALID_CYC);
  localparam logic [`OWR_CNT_W-1:0] ACK_CYC   = `OWR_CNT_W'(`OWR_ACK_CYC);
  localparam logic [7:0]            OWN_ADDR  = `OWR_ADDR_DEFAULT;

  owr_pkg::owr_state_e      state_q;
  logic                     sync1_q;
  logic                     sync2_q;
  logic                     prev_q;
  logic [`OWR_CNT_W-1:0]    cnt_q;
  logic [`OWR_CNT_W-1:0]    low_q;
  logic [`OWR_FRAME_BITS-1:0] shift_q;
  logic [4:0]               nbits_q;
  logic                     bad_q;
  logic [8:0]               bright_q;
  logic                     err_q;
  logic                     push_q;
  owr_pkg::owr_cmd_s        push_data_q;
  logic                     buf_ready;

  // edge and bit decisions on synchronised line
  wire fall       = prev_q && !sync2_q;
  wire cnt_max    = (cnt_q == {`OWR_CNT_W{1'b1}});
  wire bit_zero   = low_q >= {cnt_q[`OWR_CNT_W-2:0], 1'b0};
  wire bit_one    = cnt_q >= {low_q[`OWR_CNT_W-2:0], 1'b0};
  wire close_seen = (state_q == owr_pkg::ST_HIGH) && sync2_q
                    && (cnt_q >= CLOSE_CYC - 1'b1);
  wire full_frame = (nbits_q == 5'(`OWR_FRAME_BITS)) && !bad_q;
  wire addr_ok    = shift_q[`OWR_ADDR_MSB:`OWR_ADDR_LSB] == OWN_ADDR;
  wire ack_req    = shift_q[`OWR_ACK_REQ_BIT];
  wire good_frame = full_frame && addr_ok;
  wire [`OWR_FRAME_BITS-1:0] shift_nx = {bit_one, shift_q[`OWR_FRAME_BITS-1:1]};

  // two-flop synchroniser and edge history
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end
    else
    begin
      sync1_q <= line_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // frame decode state machine
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_q     <= owr_pkg::ST_IDLE;
      cnt_q       <= '0;
      low_q       <= '0;
      shift_q     <= '0;
      nbits_q     <= 5'h00;
      bad_q       <= 1'b0;
      bright_q    <= `OWR_BRIGHT_RESET;
      err_q       <= 1'b0;
      push_q      <= 1'b0;
      push_data_q <= '0;
    end
    else
    begin
      push_q <= 1'b0;
      case (state_q)
        owr_pkg::ST_IDLE:
        begin
          cnt_q <= '0;
          if (fall)
          begin
            state_q <= owr_pkg::ST_LOW;
            nbits_q <= 5'h00;
            bad_q   <= 1'b0;
          end
        end
        owr_pkg::ST_LOW:
        begin
          if (sync2_q) // low phase over
          begin
            low_q   <= cnt_q;
            cnt_q   <= '0;
            state_q <= owr_pkg::ST_HIGH;
          end
          else if (!cnt_max)
            cnt_q <= cnt_q + 1'b1;
        end
        owr_pkg::ST_HIGH:
        begin
          if (fall || close_seen)
          begin
            if (!bit_zero && !bit_one)
              bad_q <= 1'b1;
            if (nbits_q == 5'(`OWR_FRAME_BITS))
              bad_q <= 1'b1; // too many bits
            else
              nbits_q <= nbits_q + 5'h01;
            shift_q <= shift_nx;
            cnt_q   <= '0;
            state_q <= fall ? owr_pkg::ST_LOW : owr_pkg::ST_IDLE;
          end
          else if (!cnt_max)
            cnt_q <= cnt_q + 1'b1;
        end
        default: ;
      endcase
      // close-time check after last bit committed
      if (state_q == owr_pkg::ST_IDLE && nbits_q != 5'h00 && !fall)
      begin
        nbits_q <= 5'h00;
        err_q   <= !good_frame;
        if (good_frame)
        begin
          bright_q         <= shift_q[`OWR_BRIGHT_MSB:`OWR_BRIGHT_LSB];
          push_q           <= 1'b1;
          push_data_q.addr <= shift_q[`OWR_ADDR_MSB:`OWR_ADDR_LSB];
          push_data_q.ack_req <= ack_req;
          push_data_q.bright  <= shift_q[`OWR_BRIGHT_MSB:`OWR_BRIGHT_LSB];
          if (ack_req)
            state_q <= owr_pkg::ST_VALID;
        end
      end
      if (state_q == owr_pkg::ST_VALID)
      begin
        cnt_q <= cnt_q + 1'b1;
        if (cnt_q >= VALID_CYC - 1'b1)
        begin
          cnt_q   <= '0;
          state_q <= owr_pkg::ST_ACK;
        end
      end
      if (state_q == owr_pkg::ST_ACK)
      begin
        cnt_q <= cnt_q + 1'b1;
        if (cnt_q >= ACK_CYC - 1'b1)
        begin
          cnt_q   <= '0;
          state_q <= owr_pkg::ST_IDLE;
        end
      end
    end
  end

  // open-drain pull-down while acknowledging
  assign ack_pulldown_out = (state_q == owr_pkg::ST_ACK);
  assign line_drv_out     = 1'b0;
  assign bright_out       = bright_q;
  assign frame_err_out    = err_q;

  owr_buf u_buf (
    .clk_in      (clk_in),
    .arst_n_in   (arst_n_in),
    .s_valid_in  (push_q),
    .s_ready_out (buf_ready),
    .s_data_in   (push_data_q),
    .m_valid_out (cmd_valid_out),
    .m_ready_in  (cmd_ready_in),
    .m_data_out  (cmd_out)
  );

  // ack pulse stays on for at least eight cycles
  sequence s_ack_on;
    $rose(ack_pulldown_out);
  endsequence
  property p_ack_len;
    @(posedge clk_in) disable iff (!arst_n_in)
      s_ack_on |-> ack_pulldown_out [*8];
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack pulse too short");

  // ack only after valid delay state
  property p_ack_after_valid;
    @(posedge clk_in) disable iff (!arst_n_in)
      $rose(ack_pulldown_out) |-> $past(state_q) == owr_pkg::ST_VALID;
  endproperty
  a_ack_after_valid: assert property (p_ack_after_valid) else $error("ack w/o delay");

  // brightness changes only on good frame
  property p_bright_hold;
    @(posedge clk_in) disable iff (!arst_n_in)
      !$past(good_frame) |-> $stable(bright_q);
  endproperty
  a_bright_hold: assert property (p_bright_hold) else $error("bright changed");

  // buffer never overflows from decoder
  property p_no_drop;
    @(posedge clk_in) disable iff (!arst_n_in)
      push_q |-> buf_ready;
  endproperty
  a_no_drop: assert property (p_no_drop) else $error("command dropped");

  // new bit shifted in at msb
  property p_lsb_first;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state_q == owr_pkg::ST_HIGH && fall) |=> shift_q[22:0] == $past(shift_q[23:1]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("bit order");

  // low phase counter counts while line low
  property p_low_count;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state_q == owr_pkg::ST_LOW && !sync2_q && !cnt_max) |=> cnt_q == $past(cnt_q) + 1'b1;
  endproperty
  a_low_count: assert property (p_low_count) else $error("low count");

  // fall in high starts next low phase
  property p_bit_period;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state_q == owr_pkg::ST_HIGH && fall) |=> state_q == owr_pkg::ST_LOW;
  endproperty
  a_bit_period: assert property (p_bit_period) else $error("bit period");

  // close needs the high to persist
  property p_close;
    @(posedge clk_in) disable iff (!arst_n_in)
      (state_q == owr_pkg::ST_HIGH && !fall && cnt_q < CLOSE_CYC - 1'b1)
        |=> state_q != owr_pkg::ST_IDLE;
  endproperty
  a_close: assert property (p_close) else $error("early close");
endmodule
`default_nettype wire

/* owr_defines.svh */
// timing constants and frame field positions for the single-wire dimming receiver
`ifndef OWR_DEFINES_SVH
`define OWR_DEFINES_SVH

`define OWR_CLK_MHZ        20
`define OWR_FRAME_BITS     24
`define OWR_BRIGHT_MSB     8
`define OWR_BRIGHT_LSB     0
`define OWR_ACK_REQ_BIT    10
`define OWR_ADDR_MSB       23
`define OWR_ADDR_LSB       16
`define OWR_ADDR_DEFAULT   8'h8F
`define OWR_CLOSE_TIME_US  2
`define OWR_CLOSE_CYC      (`OWR_CLOSE_TIME_US * `OWR_CLK_MHZ)
`define OWR_VALID_TIME_US  2
`define OWR_VALID_CYC      (`OWR_VALID_TIME_US * `OWR_CLK_MHZ)
`define OWR_ACK_TIME_US    512
`define OWR_ACK_CYC        (`OWR_ACK_TIME_US * `OWR_CLK_MHZ)
`define OWR_CNT_W          14
`define OWR_BRIGHT_RESET   9'h000

`endif

/* owr_pkg.sv */
// types shared by the single-wire dimming receiver
`default_nettype none
package owr_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOW,
    ST_HIGH,
    ST_VALID,
    ST_ACK
  } owr_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic       ack_req;
    logic [8:0] bright;
  } owr_cmd_s;
endpackage
`default_nettype wire

/* owr_buf.sv */
// two-entry buffer between the decoder and the brightness consumer
`default_nettype none
module owr_buf (
  input  wire logic              clk_in,     // system clock
  input  wire logic              arst_n_in,  // async reset, low
  input  wire logic              s_valid_in, // write strobe
  output logic                   s_ready_out,// room available
  input  wire owr_pkg::owr_cmd_s s_data_in,  // word in
  output logic                   m_valid_out,// word available
  input  wire logic              m_ready_in, // consumer takes word
  output owr_pkg::owr_cmd_s      m_data_out  // word out
);
  owr_pkg::owr_cmd_s mem_q [2];
  logic              wp_q;
  logic              rp_q;
  logic [1:0]        cnt_q;
  wire               push = s_valid_in && s_ready_out;
  wire               pop  = m_valid_out && m_ready_in;

  // honest full and empty
  assign s_ready_out = (cnt_q != 2'h2);
  assign m_valid_out = (cnt_q != 2'h0);
  assign m_data_out  = mem_q[rp_q];

  // pointer and storage update
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end
    else
    begin
      if (push)
      begin
        mem_q[wp_q] <= s_data_in;
        wp_q        <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

/* owr_host.sv */
// host controller model driving the open-drain enable line
`default_nettype none
module owr_host (
  input  wire logic clk_in,          // bench clock
  input  wire logic ack_pulldown_in, // device pull-down enable
  output logic      line_out         // resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_low_q; // host pulls line low
  initial drv_low_q = 1'b0;
  // open-drain wire with pull-up, low while either side pulls
  assign line_out = ~(drv_low_q | ack_pulldown_in);
  // wait n edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  // lsb first, fall to fall; style 2 gives an ambiguous ratio
  task automatic send_frame(input logic [23:0] f, input int nbits, input int style);
    for (int i = 0; i < nbits; i++)
    begin
      drv_low_q = 1'b1;
      cyc(style == 2 ? 20 : (f[i] ? 15 : 40));
      drv_low_q = 1'b0;
      cyc(style == 2 ? 20 : (f[i] ? 40 : 15));
    end
    cyc(60); // close condition
  endtask
  // hold low 40 cycles into the ack pulse, release, sample, wait for the pulse end
  task automatic ack_read(output logic seen_low, output logic ended);
    drv_low_q = 1'b1;
    cyc(40);
    drv_low_q = 1'b0;
    cyc(20);
    seen_low = ~line_out;
    ended = 1'b0;
    for (int i = 0; i < 12000 && !ended; i++)
    begin
      cyc(1);
      ended = ~ack_pulldown_in;
    end
  endtask
endmodule
`default_nettype wire

/* tb_owr_rx.sv */
// self-checking bench for the single-wire dimming receiver
`include "owr_defines.svh"
`default_nettype none
module tb_owr_rx;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_in = 1'b0;
  logic              arst_n_in = 1'b0;
  logic              cmd_ready_in = 1'b0;
  logic              hold_ready = 1'b0;
  logic              line;
  logic              ack;
  logic              drv;
  logic [8:0]        bright;
  logic              cmd_valid;
  logic              frame_err;
  owr_pkg::owr_cmd_s cmd;
  owr_pkg::owr_cmd_s exp_q[$];
  logic [31:0]       lfsr = 32'h3761;
  logic [8:0]        last_bright = `OWR_BRIGHT_RESET;
  logic              seen_low;
  logic              ended;
  int                ack_cnt = 0;
  int                n_fail = 0;
  int                n_compared = 0;

  always #25 clk_in = ~clk_in;

  owr_rx dut (
    .clk_in           (clk_in),
    .arst_n_in        (arst_n_in),
    .line_in          (line),
    .ack_pulldown_out (ack),
    .line_drv_out     (drv),
    .bright_out       (bright),
    .cmd_ready_in     (cmd_ready_in),
    .cmd_valid_out    (cmd_valid),
    .cmd_out          (cmd),
    .frame_err_out    (frame_err)
  );
  owr_host host (.clk_in(clk_in), .ack_pulldown_in(ack), .line_out(line));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // random consumer ready unless held off
  always @(posedge clk_in)
  begin
    lfsr <= lfsr_next(lfsr);
    cmd_ready_in <= #2 ~hold_ready & lfsr[0];
    if (ack === 1'b1)
      ack_cnt <= ack_cnt + 1;
  end

  // monitor: each accepted command against the oldest note
  always @(posedge clk_in)
    if (arst_n_in && cmd_valid === 1'b1 && cmd_ready_in === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("cmd_extra", 32'(cmd), 32'hFFFFFFFF);
      else
        check("cmd_out", 32'(cmd), 32'(exp_q.pop_front()));
    end

  // style 0 good, 1 other address, 2 ambiguous ratio, 3 short frame
  task automatic frame(input logic req, input int style);
    logic [8:0] b;
    logic [7:0] a;
    logic       good;
    b = lfsr[8:0];
    a = (style == 1) ? 8'h8E : `OWR_ADDR_DEFAULT;
    good = (style == 0);
    if (good)
    begin
      exp_q.push_back(owr_pkg::owr_cmd_s'{a, req, b});
      last_bright = b;
    end
    ack_cnt = 0;
    host.send_frame({a, 5'h00, req, 1'b0, b}, style == 3 ? 23 : 24, style);
    host.cyc(5);
    check("bright_out", 32'(bright), 32'(last_bright));
    check("frame_err_out", 32'(frame_err), 32'(!good));
    if (good && req)
    begin
      host.ack_read(seen_low, ended);
      check("ack_seen", 32'(seen_low), 32'h1);
      check("ack_ended", 32'(ended), 32'h1);
      if (!ended)
        end_of_test();
      host.cyc(2);
      check("ack_cycles", ack_cnt, `OWR_ACK_CYC);
    end
    else
    begin
      host.cyc(100);
      check("ack_cycles", ack_cnt, 0);
    end
  endtask

  // main sequence
  initial
  begin
    #102 arst_n_in = 1'b1;
    host.cyc(45); // line idles high
    check("line_drv_out", 32'(drv), 32'h0);
    check("bright_out", 32'(bright), 32'(`OWR_BRIGHT_RESET));
    frame(1'b0, 0); // no start condition needed
    frame(1'b1, 0);
    for (int s = 1; s < 4; s++)
      frame(1'b1, s);
    hold_ready = 1'b1;
    frame(lfsr[2], 0);
    frame(lfsr[5], 0);
    check("cmd_valid_out", 32'(cmd_valid), 32'h1);
    hold_ready = 1'b0;
    for (int i = 0; i < 300 && (exp_q.size() > 0 || cmd_valid !== 1'b0); i++)
      host.cyc(1);
    check("left_over", exp_q.size(), 0);
    arst_n_in = 1'b0;
    host.cyc(2);
    check("bright_out", 32'(bright), 32'(`OWR_BRIGHT_RESET));
    check("cmd_valid_out", 32'(cmd_valid), 32'h0);
    arst_n_in = 1'b1;
    last_bright = `OWR_BRIGHT_RESET;
    host.cyc(3); // sync depth after release
    frame(lfsr[3], 0);
    for (int i = 0; i < 300 && exp_q.size() > 0; i++)
      host.cyc(1);
    check("left_over", exp_q.size(), 0);
    end_of_test();
  end
endmodule
`default_nettype wire
